// >>> rtl/oipc_pkg.sv
// package: constants and types for the output inhibit pin control block
package oipc_pkg;
    // pin function select
    typedef enum logic [1:0] {
        OIPC_FN_LEVEL_INH,
        OIPC_FN_PULSE_INH,
        OIPC_FN_INPUT,
        OIPC_FN_OUTPUT
    } oipc_func_t;

    // output source select
    typedef enum logic [1:0] {
        OIPC_SRC_ONE,
        OIPC_SRC_ZERO,
        OIPC_SRC_PWM
    } oipc_src_t;

    // register offsets
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_PWMPER  = 4'h1;
    localparam logic [3:0] ADDR_PWMDUTY = 4'h2;
    localparam logic [3:0] ADDR_SWITCH  = 4'h3;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_LEVEL   = 4'h5;
    localparam logic [3:0] ADDR_RAMP    = 4'h6;

    // control field positions
    localparam int CTRL_INV_BIT  = 0;
    localparam int CTRL_FN_LSB   = 1;
    localparam int CTRL_SRC_LSB  = 3;

    // switch / status field positions
    localparam int SW_ON_BIT      = 0;
    localparam int SW_CLRPROT_BIT = 1;
    localparam int ST_ON_BIT      = 0;
    localparam int ST_SUPP_BIT    = 1;
    localparam int ST_PROT_BIT    = 2;
    localparam int ST_PIN_BIT     = 3;

    localparam int DATA_W  = 16;
    localparam int LEVEL_W = 16;

    // reset values
    localparam logic [4:0]        CTRL_RST     = 5'h00;
    localparam logic [DATA_W-1:0] PWMPER_RST   = 16'h03e8;
    localparam logic [DATA_W-1:0] PWMDUTY_RST  = 16'h01f4;
    localparam logic [LEVEL_W-1:0] LEVEL_RST   = 16'h0000;
    localparam logic [LEVEL_W-1:0] RAMP_RST    = 16'h0001;

    // trip pulse minimum low width
    localparam int CLK_MHZ       = 100;
    localparam int TRIP_MIN_US   = 30;
    localparam int TRIP_MIN_CYC  = TRIP_MIN_US * CLK_MHZ;
    localparam int TRIP_CNT_W    = 12;
endpackage

// >>> rtl/oipc_pin_sync.sv
// two flip-flop synchroniser with trip pulse width qualifier
`timescale 1ns/1ps
module oipc_pin_sync (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic pinIn,
    output logic      pinSync,
    output logic      lowQualified
);
    logic                            meta_r;
    logic                            sync_r;
    logic [oipc_pkg::TRIP_CNT_W-1:0] lowCnt_r;
    logic [oipc_pkg::TRIP_CNT_W-1:0] lowCnt_nxt;
    logic                            qual_r;
    logic                            qual_nxt;

    // ******************************
    // low time measurement
    // ******************************
    always_comb begin
        lowCnt_nxt = lowCnt_r;
        qual_nxt   = 1'b0;
        if (sync_r) begin
            lowCnt_nxt = '0;
        end else if (lowCnt_r < oipc_pkg::TRIP_CNT_W'(oipc_pkg::TRIP_MIN_CYC)) begin
            lowCnt_nxt = lowCnt_r + 1'b1;
            // one-cycle pulse when the low time reaches the minimum
            qual_nxt   = (lowCnt_r == oipc_pkg::TRIP_CNT_W'(oipc_pkg::TRIP_MIN_CYC - 1));
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r   <= 1'b1;
            sync_r   <= 1'b1;
            lowCnt_r <= '0;
            qual_r   <= 1'b0;
        end else begin
            meta_r   <= pinIn;
            sync_r   <= meta_r;
            lowCnt_r <= lowCnt_nxt;
            qual_r   <= qual_nxt;
        end
    end

    assign pinSync      = sync_r;
    assign lowQualified = qual_r;
endmodule

// >>> rtl/oipc_top.sv
// output inhibit pin control: pin modes, polarity, inhibit, pwm, registers
// Contract
// - polarity setting inverts or passes pin input and output levels.
// - plain input mode samples the pin level into a readable value.
// - output mode drives constant one, constant zero or pwm.
// - normal polarity drives one as low; inverted drives it high.
// - normal polarity drives zero as high; inverted drives it low.
// - pwm frequency and duty set by two independent settings.
// - level inhibit, normal polarity: open pin reads high, no effect.
// - level inhibit active low suppresses output, switch still shows on.
// - pin releasing restores output automatically, switch stayed on.
// - inverted level inhibit: high suppresses, low releases.
// - active level inhibit sets suppress indicator and ramps output to zero.
// - pulse inhibit: valid pulse while on turns switch off, lamp off.
// - pulse inhibit, normal polarity: unconnected pin leaves switch and output alone.
// - after trip switch stays off until operator turns it on.
// - trip latches protection status; turn-on needs it cleared first.
`timescale 1ns/1ps
module oipc_top (
    input  wire logic                             clk,
    input  wire logic                             rstn,
    input  wire logic [3:0]                       regAddr,
    input  wire logic [oipc_pkg::DATA_W-1:0]      regWdata,
    input  wire logic                             regWr,
    input  wire logic                             regRd,
    output logic      [oipc_pkg::DATA_W-1:0]      regRdata,
    input  wire logic                             pinIn,
    output logic                                  pinOut,
    output logic                                  pinOe,
    output logic                                  switchOn,
    output logic                                  switchLamp,
    output logic                                  suppressIndicator,
    output logic                                  tripProtectionIndicator,
    output logic      [oipc_pkg::LEVEL_W-1:0]     deliveredLevel
);
    // ******************************
    // register state
    // ******************************
    logic [4:0]                       ctrl_r;
    logic [4:0]                       ctrl_nxt;
    logic [oipc_pkg::DATA_W-1:0]      pwmPer_r;
    logic [oipc_pkg::DATA_W-1:0]      pwmPer_nxt;
    logic [oipc_pkg::DATA_W-1:0]      pwmDuty_r;
    logic [oipc_pkg::DATA_W-1:0]      pwmDuty_nxt;
    logic [oipc_pkg::LEVEL_W-1:0]     setLevel_r;
    logic [oipc_pkg::LEVEL_W-1:0]     setLevel_nxt;
    logic [oipc_pkg::LEVEL_W-1:0]     rampStep_r;
    logic [oipc_pkg::LEVEL_W-1:0]     rampStep_nxt;
    logic [oipc_pkg::DATA_W-1:0]      rdata_r;
    logic [oipc_pkg::DATA_W-1:0]      rdata_nxt;

    logic                             on_r;
    logic                             on_nxt;
    logic                             prot_r;
    logic                             prot_nxt;
    logic                             inVal_r;
    logic                             inVal_nxt;
    logic [oipc_pkg::LEVEL_W-1:0]     level_r;
    logic [oipc_pkg::LEVEL_W-1:0]     level_nxt;
    logic [oipc_pkg::DATA_W-1:0]      pwmCnt_r;
    logic [oipc_pkg::DATA_W-1:0]      pwmCnt_nxt;
    logic                             pinOut_r;
    logic                             pinOut_nxt;
    logic                             pinOe_r;
    logic                             pinOe_nxt;

    logic                             pinSync;
    logic                             lowQualified;
    logic                             invert;
    oipc_pkg::oipc_func_t             func;
    oipc_pkg::oipc_src_t              src;
    logic                             pinActive;
    logic                             suppress;
    logic                             trip;
    logic                             outBit;
    logic                             pinLogical;
    logic [oipc_pkg::LEVEL_W:0]       rampUp;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    assign invert = ctrl_r[oipc_pkg::CTRL_INV_BIT];
    assign func   = oipc_pkg::oipc_func_t'(ctrl_r[oipc_pkg::CTRL_FN_LSB +: 2]);
    assign src    = oipc_pkg::oipc_src_t'(ctrl_r[oipc_pkg::CTRL_SRC_LSB +: 2]);

    // polarity applied ahead of the synchroniser, so the width qualifier
    // always measures the active phase; an invert change restarts it
    assign pinLogical = pinIn ^ invert;

    oipc_pin_sync u_sync (
        .clk          (clk),
        .rstn         (rstn),
        .pinIn        (pinLogical),
        .pinSync      (pinSync),
        .lowQualified (lowQualified)
    );

    // ******************************
    // inhibit decisions
    // ******************************
    // synced level is already polarity corrected: low means active
    assign pinActive = ~pinSync;
    assign suppress  = (func == oipc_pkg::OIPC_FN_LEVEL_INH) && pinActive && on_r;
    // the qualifier fires once per active phase, both polarities alike, so
    // a held pin cannot trip again until it has gone inactive
    assign trip = (func == oipc_pkg::OIPC_FN_PULSE_INH) && on_r &&
                  lowQualified;

    // ******************************
    // switch, protection, input sample
    // ******************************
    always_comb begin
        on_nxt    = on_r;
        prot_nxt  = prot_r;
        inVal_nxt = pinSync;
        if (regWr && hit(regAddr, oipc_pkg::ADDR_SWITCH)) begin
            if (regWdata[oipc_pkg::SW_CLRPROT_BIT]) begin
                prot_nxt = 1'b0;
            end
            // clear and turn-on in one write: turn-on still sees the old latch
            // turn-on refused while protection latched
            if (!regWdata[oipc_pkg::SW_ON_BIT]) begin
                on_nxt = 1'b0;
            end else if (!prot_r) begin
                on_nxt = 1'b1;
            end
        end
        // checked last so a trip beats a turn-on written in the same cycle
        if (trip) begin
            on_nxt   = 1'b0;
            prot_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            on_r    <= 1'b0;
            prot_r  <= 1'b0;
            inVal_r <= 1'b0;
        end else begin
            on_r    <= on_nxt;
            prot_r  <= prot_nxt;
            inVal_r <= inVal_nxt;
        end
    end

    // ******************************
    // delivered level ramp
    // ******************************
    // one bit wider so a large step near full scale cannot wrap
    assign rampUp = {1'b0, level_r} + {1'b0, rampStep_r};

    always_comb begin
        level_nxt = level_r;
        if (!on_r || suppress) begin
            // ramp down rather than step, saturating at zero
            if (level_r > rampStep_r) begin
                level_nxt = level_r - rampStep_r;
            end else begin
                level_nxt = '0;
            end
        end else if ({1'b0, setLevel_r} > rampUp) begin
            level_nxt = rampUp[oipc_pkg::LEVEL_W-1:0];
        end else begin
            level_nxt = setLevel_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_r <= oipc_pkg::LEVEL_RST;
        end else begin
            level_r <= level_nxt;
        end
    end

    // ******************************
    // output driver and pwm
    // ******************************
    // counter wraps on period minus one; a smaller period written mid-count
    // takes effect at once instead of running out the old count
    always_comb begin
        pwmCnt_nxt = pwmCnt_r + 1'b1;
        if (pwmCnt_r >= pwmPer_r - 1'b1) begin
            pwmCnt_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwmCnt_r <= '0;
        end else begin
            pwmCnt_r <= pwmCnt_nxt;
        end
    end

    always_comb begin
        case (src)
            oipc_pkg::OIPC_SRC_ONE:  outBit = 1'b1;
            oipc_pkg::OIPC_SRC_ZERO: outBit = 1'b0;
            oipc_pkg::OIPC_SRC_PWM:  outBit = (pwmCnt_r < pwmDuty_r);
            default:                 outBit = 1'b0;
        endcase
        pinOe_nxt  = (func == oipc_pkg::OIPC_FN_OUTPUT);
        // logic one pulls low when not inverted
        pinOut_nxt = outBit ? invert : ~invert;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinOut_r <= 1'b1;
            pinOe_r  <= 1'b0;
        end else begin
            pinOut_r <= pinOut_nxt;
            pinOe_r  <= pinOe_nxt;
        end
    end

    // ******************************
    // register bus
    // ******************************
    always_comb begin
        ctrl_nxt     = ctrl_r;
        pwmPer_nxt   = pwmPer_r;
        pwmDuty_nxt  = pwmDuty_r;
        setLevel_nxt = setLevel_r;
        rampStep_nxt = rampStep_r;
        if (regWr) begin
            if (hit(regAddr, oipc_pkg::ADDR_CTRL)) begin
                ctrl_nxt = regWdata[4:0];
            end else if (hit(regAddr, oipc_pkg::ADDR_PWMPER)) begin
                pwmPer_nxt = regWdata;
            end else if (hit(regAddr, oipc_pkg::ADDR_PWMDUTY)) begin
                pwmDuty_nxt = regWdata;
            end else if (hit(regAddr, oipc_pkg::ADDR_LEVEL)) begin
                setLevel_nxt = regWdata;
            end else if (hit(regAddr, oipc_pkg::ADDR_RAMP)) begin
                rampStep_nxt = regWdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r     <= oipc_pkg::CTRL_RST;
            pwmPer_r   <= oipc_pkg::PWMPER_RST;
            pwmDuty_r  <= oipc_pkg::PWMDUTY_RST;
            setLevel_r <= oipc_pkg::LEVEL_RST;
            rampStep_r <= oipc_pkg::RAMP_RST;
        end else begin
            ctrl_r     <= ctrl_nxt;
            pwmPer_r   <= pwmPer_nxt;
            pwmDuty_r  <= pwmDuty_nxt;
            setLevel_r <= setLevel_nxt;
            rampStep_r <= rampStep_nxt;
        end
    end

    // ******************************
    // read data
    // ******************************
    // registered and cleared between reads, so the word stands one cycle
    always_comb begin
        rdata_nxt = '0;
        if (regRd) begin
            if (hit(regAddr, oipc_pkg::ADDR_CTRL)) begin
                rdata_nxt = {11'h000, ctrl_r};
            end else if (hit(regAddr, oipc_pkg::ADDR_PWMPER)) begin
                rdata_nxt = pwmPer_r;
            end else if (hit(regAddr, oipc_pkg::ADDR_PWMDUTY)) begin
                rdata_nxt = pwmDuty_r;
            end else if (hit(regAddr, oipc_pkg::ADDR_SWITCH)) begin
                rdata_nxt = {15'h0000, on_r};
            end else if (hit(regAddr, oipc_pkg::ADDR_STATUS)) begin
                rdata_nxt[oipc_pkg::ST_ON_BIT]   = on_r;
                rdata_nxt[oipc_pkg::ST_SUPP_BIT] = suppress;
                rdata_nxt[oipc_pkg::ST_PROT_BIT] = prot_r;
                rdata_nxt[oipc_pkg::ST_PIN_BIT]  = inVal_r;
            end else if (hit(regAddr, oipc_pkg::ADDR_LEVEL)) begin
                rdata_nxt = setLevel_r;
            end else if (hit(regAddr, oipc_pkg::ADDR_RAMP)) begin
                rdata_nxt = rampStep_r;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign regRdata                = rdata_r;
    assign pinOut                  = pinOut_r;
    assign pinOe                   = pinOe_r;
    assign switchOn                = on_r;
    assign switchLamp              = on_r;
    assign suppressIndicator       = suppress;
    assign tripProtectionIndicator = prot_r;
    assign deliveredLevel          = level_r;
endmodule

// >>> tb/oipc_checker.sv
// checker: port-level properties of the output inhibit pin control
`timescale 1ns/1ps
module oipc_checker (
    input wire logic                        clk,
    input wire logic                        rstn,
    input wire logic [3:0]                  regAddr,
    input wire logic [oipc_pkg::DATA_W-1:0] regWdata,
    input wire logic                        regWr,
    input wire logic                        regRd,
    input wire logic [oipc_pkg::DATA_W-1:0] regRdata,
    input wire logic                        pinIn,
    input wire logic                        pinOut,
    input wire logic                        pinOe,
    input wire logic                        switchOn,
    input wire logic                        switchLamp,
    input wire logic                        suppressIndicator,
    input wire logic                        tripProtectionIndicator,
    input wire logic [oipc_pkg::LEVEL_W-1:0] deliveredLevel
);
    // ********************
    // properties
    // ********************
    logic onReq_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            onReq_r <= 1'h0;
        end else begin
            onReq_r <= regWr && regAddr == oipc_pkg::ADDR_SWITCH && regWdata[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // output function write, taken at this edge
    sequence s_ctrlOut;
        regWr && regAddr == oipc_pkg::ADDR_CTRL && regWdata[2:1] == 2'h3;
    endsequence
    property p_outOne;
        s_ctrlOut ##0 regWdata[4:3] == 2'h0 |-> ##2 pinOe && pinOut == $past(regWdata[0], 2);
    endproperty
    property p_outZero;
        s_ctrlOut ##0 regWdata[4:3] == 2'h1 |-> ##2 pinOe && pinOut != $past(regWdata[0], 2);
    endproperty
    property p_lamp;
        switchLamp == switchOn;
    endproperty
    property p_protOff;
        $rose(tripProtectionIndicator) |-> !switchOn && !switchLamp;
    endproperty
    property p_protHold;
        tripProtectionIndicator |-> !switchOn;
    endproperty
    property p_onCause;
        $rose(switchOn) |-> onReq_r;
    endproperty
    property p_supRamp;
        suppressIndicator && $past(suppressIndicator) |-> deliveredLevel <= $past(deliveredLevel);
    endproperty
    property p_rdStatus;
        regRd && regAddr == oipc_pkg::ADDR_STATUS |=> regRdata[2:0] ==
            {$past(tripProtectionIndicator), $past(suppressIndicator), $past(switchOn)};
    endproperty
    a_outOne: assert property (p_outOne) else $error("pin not at one level");
    a_outZero: assert property (p_outZero) else $error("pin not at zero level");
    a_lamp: assert property (p_lamp) else $error("lamp differs from switch");
    a_protOff: assert property (p_protOff) else $error("trip left switch on");
    a_protHold: assert property (p_protHold) else $error("switch on while latched");
    a_onCause: assert property (p_onCause) else $error("switch on without request");
    a_supRamp: assert property (p_supRamp) else $error("level rose while suppressed");
    a_rdStatus: assert property (p_rdStatus) else $error("status read mismatch");
endmodule
bind oipc_top oipc_checker u_chk (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .switchOn(switchOn), .switchLamp(switchLamp),
    .suppressIndicator(suppressIndicator), .tripProtectionIndicator(tripProtectionIndicator),
    .deliveredLevel(deliveredLevel));

// >>> tb/oipc_ext_ctrl.sv
// partner: external controller that holds or pulses the pin low
`timescale 1ns/1ps
module oipc_ext_ctrl #(
    parameter int LOW_CYC = 3010
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic holdLow,
    input  wire logic pulseReq,
    input  wire logic pinOe,
    input  wire logic pinOut,
    output logic      pinLvl
);
    logic [12:0] lowCnt_r;
    // margin over the minimum low width
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lowCnt_r <= 13'h0000;
        end else if (pulseReq) begin
            lowCnt_r <= 13'(LOW_CYC);
        end else if (lowCnt_r != 13'h0000) begin
            lowCnt_r <= lowCnt_r - 13'h0001;
        end
    end
    // released pin floats high through the pull-up
    assign pinLvl = pinOe ? pinOut : !(holdLow || lowCnt_r != 13'h0000);
endmodule

// >>> tb/tb_top.sv
// testbench: scenarios for the output inhibit pin control
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'h0;
    logic        rstn, regWr, regRd, holdLow, pulseReq, pinIn, pinOut, pinOe;
    logic        switchOn, switchLamp, supp, trip;
    logic [3:0]  regAddr;
    logic [15:0] regWdata, regRdata, level, rv;
    int          failures = 0;
    int          samplesChecked = 0;
    int          n;
    always #5 clk = ~clk;
    oipc_top dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .switchOn(switchOn), .switchLamp(switchLamp),
        .suppressIndicator(supp), .tripProtectionIndicator(trip), .deliveredLevel(level));
    oipc_ext_ctrl ext (.clk(clk), .rstn(rstn), .holdLow(holdLow), .pulseReq(pulseReq),
        .pinOe(pinOe), .pinOut(pinOut), .pinLvl(pinIn));
    // ********************
    // bus and check tasks
    // ********************
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'h0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'h0;
        #1 rv = regRdata;
    endtask
    task cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task pin(input logic low);
        @(posedge clk);
        holdLow <= low;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samplesChecked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task lows(input int c);
        n = 0;
        repeat (c) begin
            @(posedge clk);
            #1 n += int'(pinOut === 1'h0);
        end
    endtask
    task finish_test;
        $display("failures %0d samples checked %0d", failures, samplesChecked);
        if (failures == 0 && samplesChecked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ********************
    // scenarios
    // ********************
    task t_out;
        rd(4'hf);
        chk("unmapped", 16'h0000, rv);
        for (int i = 0; i < 4; i++) begin
            wr(oipc_pkg::ADDR_CTRL, 16'(i[1] * 8 + 6 + i[0]));
            cyc(2);
            chk("pinOe", 16'h0001, 16'(pinOe));
            chk("pinOut", 16'(i[0] ^ i[1]), 16'(pinOut));
        end
        rd(oipc_pkg::ADDR_PWMPER);
        chk("period", oipc_pkg::PWMPER_RST, rv);
        wr(oipc_pkg::ADDR_PWMPER, 16'h000a);
        wr(oipc_pkg::ADDR_PWMDUTY, 16'h0003);
        wr(oipc_pkg::ADDR_CTRL, 16'h0016);
        lows(10);
        lows(10);
        chk("pwm lows", 16'h0003, 16'(n));
        wr(oipc_pkg::ADDR_PWMDUTY, 16'h0007);
        lows(12);
        lows(10);
        chk("pwm lows", 16'h0007, 16'(n));
        wr(oipc_pkg::ADDR_PWMPER, 16'h0014);
        lows(22);
        lows(20);
        chk("pwm lows", 16'h0007, 16'(n));
    endtask
    task t_in;
        pin(1'h1);
        for (int i = 0; i < 2; i++) begin
            wr(oipc_pkg::ADDR_CTRL, 16'(4 + i));
            cyc(4);
            rd(oipc_pkg::ADDR_STATUS);
            chk("input bit", 16'(i), 16'(rv[3]));
            chk("pinOe", 16'h0000, 16'(pinOe));
        end
        pin(1'h0);
    endtask
    task t_level;
        wr(oipc_pkg::ADDR_LEVEL, 16'h0010);
        wr(oipc_pkg::ADDR_CTRL, 16'h0000);
        wr(oipc_pkg::ADDR_SWITCH, 16'h0001);
        cyc(40);
        chk("level", 16'h0010, level);
        chk("suppress", 16'h0000, 16'(supp));
        pin(1'h1);
        cyc(40);
        chk("level", 16'h0000, level);
        chk("lamp", 16'h0001, 16'(switchLamp));
        rd(oipc_pkg::ADDR_STATUS);
        chk("status", 16'h0003, rv);
        pin(1'h0);
        cyc(40);
        chk("level", 16'h0010, level);
        chk("suppress", 16'h0000, 16'(supp));
        wr(oipc_pkg::ADDR_CTRL, 16'h0001);
        cyc(4);
        chk("suppress", 16'h0001, 16'(supp));
        pin(1'h1);
        cyc(40);
        chk("level", 16'h0010, level);
        pin(1'h0);
    endtask
    task t_pulse;
        wr(oipc_pkg::ADDR_CTRL, 16'h0002);
        cyc(100);
        chk("on", 16'h0001, 16'(switchOn));
        pin(1'h1);
        cyc(200);
        pin(1'h0);
        cyc(10);
        chk("on", 16'h0001, 16'(switchOn));
        @(posedge clk) pulseReq <= 1'h1;
        @(posedge clk) pulseReq <= 1'h0;
        cyc(3100);
        chk("lamp", 16'h0000, 16'(switchLamp));
        chk("protect", 16'h0001, 16'(trip));
        wr(oipc_pkg::ADDR_SWITCH, 16'h0001);
        cyc(3);
        chk("on", 16'h0000, 16'(switchOn));
        wr(oipc_pkg::ADDR_SWITCH, 16'h0003);
        cyc(3);
        chk("on", 16'h0000, 16'(switchOn));
        chk("protect", 16'h0000, 16'(trip));
        wr(oipc_pkg::ADDR_SWITCH, 16'h0001);
        cyc(3);
        chk("on", 16'h0001, 16'(switchOn));
        pin(1'h1);
        wr(oipc_pkg::ADDR_CTRL, 16'h0003);
        cyc(10);
        chk("on", 16'h0001, 16'(switchOn));
        pin(1'h0);
        cyc(3100);
        chk("inverted trip", 16'h0001, 16'(trip));
        chk("on", 16'h0000, 16'(switchOn));
    endtask
    initial begin
        rstn = 1'h0;
        {regWr, regRd, holdLow, pulseReq, regAddr, regWdata} = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'h1;
        t_out();
        t_in();
        t_level();
        t_pulse();
        finish_test();
    end
    // hang guard, nearly three times the expected run
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule
